/* bfs_fault_status.sv */
// Stacking, unstacking and imprecise bus fault flags with pending control.
// Assumes the core gives one-cycle event pulses and a decoded status-register access.
//
// What this block does
// - Stacking fault during exception entry sets flag bit 12; resets to zero.
// - Stacking fault still adjusts stack pointer; fault address not loaded.
// - Unstacking fault during exception return sets flag bit 11; resets to zero.
// - Unstacking fault chains to handler, no stack adjust, no save, no address.
// - Imprecise data bus error sets flag bit 10; resets to zero.
// - Imprecise error never loads the fault address register.
// - Imprecise fault stays pending while execution priority outranks or equals bus fault.
// - Precise fault before imprecise handler leaves both flags set together.
// - Writing one clears a flag; writing zero leaves it unchanged.
`timescale 1ns/1ps
`include "bfs_regs.svh"
module bfs_fault_status
  import bfs_pkg::*;
#(
  parameter int ADDR_W = `BFS_ADDR_W,
  parameter int PRIO_W = `BFS_PRIO_W
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              stack_fault,
  input  wire logic              unstack_fault,
  input  wire logic              imprecise_fault,
  input  wire logic              precise_fault,
  input  wire logic [ADDR_W-1:0] precise_addr,
  input  wire logic [PRIO_W-1:0] exec_prio,
  input  wire logic [PRIO_W-1:0] bus_fault_prio,
  input  wire logic              status_wr,
  input  wire logic [31:0]       status_wdata,
  input  wire logic              status_rd,
  output logic [31:0]            status_rdata,
  output logic                   stacking_bus_fault_flag,
  output logic                   unstacking_bus_fault_flag,
  output logic                   imprecise_bus_error_flag,
  output logic                   precise_flag,
  output logic                   addr_valid,
  output logic [ADDR_W-1:0]      bus_fault_address_register,
  output logic                   sp_adjust,
  output logic                   chain_to_handler,
  output logic                   imprecise_activate
);
  // Status word is 32 bits wide, so wider fields cannot be served
  if (ADDR_W < 1 || ADDR_W > 32 || PRIO_W < 1 || PRIO_W > 32) begin : g_bad_param
    $error("bfs_fault_status: unsupported parameter width");
  end

  bfs_imp_state_t imp_state;
  logic           wr_clr_stk;
  logic           wr_clr_unstk;
  logic           wr_clr_imp;
  logic           wr_clr_prec;
  logic           prio_blocks;

  function automatic logic w1c_hit(input logic wr, input logic [31:0] d, input int pos);
    return wr & d[pos];
  endfunction : w1c_hit

  assign wr_clr_stk   = w1c_hit(status_wr, status_wdata, `BFS_STK_BIT);
  assign wr_clr_unstk = w1c_hit(status_wr, status_wdata, `BFS_UNSTK_BIT);
  assign wr_clr_imp   = w1c_hit(status_wr, status_wdata, `BFS_IMPRECISE_BUS_ERROR_FLAG_BIT);
  assign wr_clr_prec  = w1c_hit(status_wr, status_wdata, `BFS_PRECISE_BIT);
  // Lower number means higher priority, as in the core's exception model
  assign prio_blocks  = (exec_prio <= bus_fault_prio);

  // Set wins over a clear in the same cycle so no fault is lost
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stacking_bus_fault_flag   <= `BFS_FLAG_RESET;
      unstacking_bus_fault_flag <= `BFS_FLAG_RESET;
      imprecise_bus_error_flag  <= `BFS_FLAG_RESET;
      precise_flag              <= `BFS_FLAG_RESET;
    end else if (clk_en) begin
      if (stack_fault) stacking_bus_fault_flag <= 1'b1;
      else if (wr_clr_stk) stacking_bus_fault_flag <= 1'b0;
      if (unstack_fault) unstacking_bus_fault_flag <= 1'b1;
      else if (wr_clr_unstk) unstacking_bus_fault_flag <= 1'b0;
      if (imprecise_fault) imprecise_bus_error_flag <= 1'b1;
      else if (wr_clr_imp) imprecise_bus_error_flag <= 1'b0;
      // Precise set is independent of the imprecise flag
      if (precise_fault) precise_flag <= 1'b1;
      else if (wr_clr_prec) precise_flag <= 1'b0;
    end
  end

  // Only precise errors carry a known address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_fault_address_register <= ADDR_W'(`BFS_ADDR_RESET);
      addr_valid                 <= 1'b0;
    end else if (clk_en) begin
      if (precise_fault) begin
        bus_fault_address_register <= precise_addr;
        addr_valid                 <= 1'b1;
      end
    end
  end

  // Stacking fault keeps the SP adjust; unstacking fault chains
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sp_adjust        <= 1'b0;
      chain_to_handler <= 1'b0;
    end else if (clk_en) begin
      sp_adjust        <= stack_fault;
      chain_to_handler <= unstack_fault;
    end
  end

  // Pending imprecise fault waits for priority to drop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      imp_state          <= BFS_IDLE;
      imprecise_activate <= 1'b0;
    end else if (clk_en) begin
      imprecise_activate <= 1'b0;
      unique case (imp_state)
        BFS_IDLE: begin
          if (imprecise_fault) begin
            if (prio_blocks) imp_state <= BFS_PENDING;
            else imprecise_activate <= 1'b1;
          end
        end
        BFS_PENDING: begin
          if (!prio_blocks) begin
            imp_state          <= BFS_IDLE;
            imprecise_activate <= 1'b1;
          end
        end
        default: imp_state <= BFS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      status_rdata <= 32'h0000_0000;
      if (status_rd) begin
        status_rdata[`BFS_STK_BIT]     <= stacking_bus_fault_flag;
        status_rdata[`BFS_UNSTK_BIT]   <= unstacking_bus_fault_flag;
        status_rdata[`BFS_IMPRECISE_BUS_ERROR_FLAG_BIT]   <= imprecise_bus_error_flag;
        status_rdata[`BFS_PRECISE_BIT] <= precise_flag;
      end
    end
  end

  AST_STK_SET: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && stack_fault |=> stacking_bus_fault_flag)
    else $error("stacking flag not set");
  AST_UNSTK_SET: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && unstack_fault |=> unstacking_bus_fault_flag && chain_to_handler)
    else $error("unstacking flag or chain missing");
  AST_IMP_SET: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && imprecise_fault |=> imprecise_bus_error_flag)
    else $error("imprecise flag not set");
  AST_NO_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !precise_fault |=> $stable(bus_fault_address_register))
    else $error("fault address loaded without precise error");
  AST_SP_ADJ: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && stack_fault |=> sp_adjust)
    else $error("stack pointer not adjusted on stacking fault");
  AST_PEND: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && prio_blocks |=> !imprecise_activate)
    else $error("imprecise fault activated while blocked");
  AST_BOTH: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && imprecise_bus_error_flag && precise_fault && !wr_clr_imp
      |=> imprecise_bus_error_flag && precise_flag)
    else $error("precise fault dropped imprecise flag");
  AST_W0_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && stacking_bus_fault_flag && !wr_clr_stk |=> stacking_bus_fault_flag)
    else $error("stacking flag lost without clear");
  AST_W1_CLR: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_clr_unstk && !unstack_fault |=> !unstacking_bus_fault_flag)
    else $error("unstacking flag not cleared by write one");
  AST_READ: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && status_rd |=> status_rdata[`BFS_IMPRECISE_BUS_ERROR_FLAG_BIT] == $past(imprecise_bus_error_flag))
    else $error("read does not show imprecise flag");

  // Clear and hold behaviour of the other flags
  AST_STK_CLR: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_clr_stk && !stack_fault |=> !stacking_bus_fault_flag)
    else $error("stacking flag not cleared by write one");
  AST_IMP_CLR: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_clr_imp && !imprecise_fault |=> !imprecise_bus_error_flag)
    else $error("imprecise flag not cleared by write one");
  AST_UNSTK_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && unstacking_bus_fault_flag && !wr_clr_unstk |=> unstacking_bus_fault_flag)
    else $error("unstacking flag lost without clear");
  AST_IMP_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && imprecise_bus_error_flag && !wr_clr_imp |=> imprecise_bus_error_flag)
    else $error("imprecise flag lost without clear");
  AST_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(stacking_bus_fault_flag) && $stable(unstacking_bus_fault_flag)
      && $stable(imprecise_bus_error_flag) && $stable(imp_state))
    else $error("state moved while clock enable low");

  // Side effects of stacking, unstacking and precise faults
  AST_STK_NO_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && stack_fault && !precise_fault |=> $stable(addr_valid)
      && $stable(bus_fault_address_register))
    else $error("stacking fault touched the fault address");
  AST_SP_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !stack_fault |=> !sp_adjust)
    else $error("stack pointer adjust without stacking fault");
  AST_UNSTK_NO_SP: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && unstack_fault && !stack_fault |=> !sp_adjust)
    else $error("unstacking fault adjusted the stack pointer");
  AST_CHAIN_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !unstack_fault |=> !chain_to_handler)
    else $error("chain to handler without unstacking fault");
  AST_PREC_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && precise_fault |=> addr_valid && bus_fault_address_register == $past(precise_addr))
    else $error("precise fault address not captured");

  // Pending control of the imprecise fault
  AST_ACT_NOW: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && imp_state == BFS_IDLE && imprecise_fault && !prio_blocks |=> imprecise_activate)
    else $error("unblocked imprecise fault not activated");
  AST_PEND_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && imp_state == BFS_PENDING && prio_blocks |=> imp_state == BFS_PENDING)
    else $error("pending imprecise fault dropped while blocked");
  AST_ONEHOT: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot(imp_state))
    else $error("pending state code not one-hot");

  // Read port shows flags only for a requested read
  AST_RD_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !status_rd |=> status_rdata == 32'h0000_0000)
    else $error("read data not zero without a read");
  AST_RD_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && status_rd |=> status_rdata[`BFS_STK_BIT] == $past(stacking_bus_fault_flag)
      && status_rdata[`BFS_UNSTK_BIT] == $past(unstacking_bus_fault_flag))
    else $error("read does not show stacking flags");
endmodule : bfs_fault_status

/* bfs_regs.svh */
// Bit positions, reset values and widths for the bus fault status flags.
// Included by the package and the fault status module; definitions only.
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH
`define BFS_STK_BIT     12
`define BFS_UNSTK_BIT   11
`define BFS_IMPRECISE_BUS_ERROR_FLAG_BIT   10
`define BFS_PRECISE_BIT 9
`define BFS_FLAG_RESET  1'b0
`define BFS_ADDR_W      32
`define BFS_PRIO_W      8
`define BFS_ADDR_RESET  32'h0000_0000
`endif

/* bfs_pkg.sv */
// Types shared by the bus fault status logic.
// Assumes bfs_regs.svh is on the include path.
`include "bfs_regs.svh"
package bfs_pkg;
  typedef enum logic [1:0] {
    BFS_IDLE    = 2'b01,
    BFS_PENDING = 2'b10
  } bfs_imp_state_t;
endpackage : bfs_pkg

/* bfs_core_model.sv */
// Core-side model: exception entry/return and data bus fault pulses.
// Assumes the bench calls fire() while the clock runs.
`timescale 1ns/1ps
module bfs_core_model (
  input  wire logic   clock,
  output logic        stack_fault,
  output logic        unstack_fault,
  output logic        imprecise_fault,
  output logic        precise_fault,
  output logic [31:0] precise_addr
);
  initial {stack_fault, unstack_fault, imprecise_fault, precise_fault} = 4'h0;
  initial precise_addr = 32'h0;
  // One-cycle pulse, changed only at falling edges
  task automatic fire(input logic [3:0] kind, input logic [31:0] addr);
    @(negedge clock);
    {stack_fault, unstack_fault, imprecise_fault, precise_fault} = kind;
    precise_addr = addr;
    @(negedge clock);
    {stack_fault, unstack_fault, imprecise_fault, precise_fault} = 4'h0;
    // Stale address inverted so it never passes by chance
    precise_addr = ~addr;
  endtask : fire
endmodule : bfs_core_model

/* bus_fault_status_bits_tb.sv */
// Self-checking bench for the bus fault status flags.
// Assumes bfs_core_model drives the fault pulses; clk_en driven by the bench.
`timescale 1ns/1ps
module bus_fault_status_bits_tb;
  logic clock = 1'b0, rst_n = 1'b0, status_wr = 1'b0, status_rd = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] status_wdata = 32'h0, status_rdata, precise_addr, bus_fault_address_register;
  logic [7:0] exec_prio = 8'h0, bus_fault_prio = 8'h0;
  logic stack_fault, unstack_fault, imprecise_fault, precise_fault;
  logic stacking_bus_fault_flag, unstacking_bus_fault_flag, imprecise_bus_error_flag;
  logic precise_flag, addr_valid, sp_adjust, chain_to_handler, imprecise_activate;
  int failures = 0, cmp_count = 0, act_n = 0;
  always #5 clock = ~clock;
  bfs_core_model u_core (.clock(clock), .stack_fault(stack_fault), .unstack_fault(unstack_fault),
    .imprecise_fault(imprecise_fault), .precise_fault(precise_fault), .precise_addr(precise_addr));
  bfs_fault_status u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .stack_fault(stack_fault),
    .unstack_fault(unstack_fault), .imprecise_fault(imprecise_fault), .precise_fault(precise_fault),
    .precise_addr(precise_addr), .exec_prio(exec_prio), .bus_fault_prio(bus_fault_prio),
    .status_wr(status_wr), .status_wdata(status_wdata), .status_rd(status_rd),
    .status_rdata(status_rdata), .stacking_bus_fault_flag(stacking_bus_fault_flag),
    .unstacking_bus_fault_flag(unstacking_bus_fault_flag), .precise_flag(precise_flag),
    .imprecise_bus_error_flag(imprecise_bus_error_flag), .addr_valid(addr_valid),
    .bus_fault_address_register(bus_fault_address_register), .sp_adjust(sp_adjust),
    .chain_to_handler(chain_to_handler), .imprecise_activate(imprecise_activate));
  // Activation pulses counted, so a stray early one is seen
  always @(posedge clock) #1 if (imprecise_activate === 1'b1) act_n++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [31:0] d);
    @(negedge clock);
    status_wr = 1'b1;
    status_wdata = d;
    @(negedge clock);
    status_wr = 1'b0;
  endtask : wr
  task automatic rd(output logic [31:0] q);
    @(negedge clock);
    status_rd = 1'b1;
    @(negedge clock);
    status_rd = 1'b0;
    q = status_rdata;
  endtask : rd
  task automatic t_stack;
    logic [31:0] q;
    u_core.fire(4'h8, 32'h0);
    chk(32'(stacking_bus_fault_flag), 32'h1, "stack flag");
    chk({30'h0, sp_adjust, addr_valid}, 32'h2, "stack sp or addr");
    u_core.fire(4'h8, 32'h0);
    wr(32'h0);
    rd(q);
    chk(q, 32'h1000, "stack flag lost");
    wr(32'h1000);
    chk(32'(stacking_bus_fault_flag), 32'h0, "stack clear");
    $display("test stack done");
  endtask : t_stack
  task automatic t_unstack;
    u_core.fire(4'h4, 32'h0);
    chk(32'(unstacking_bus_fault_flag), 32'h1, "unstack flag");
    chk({29'h0, chain_to_handler, sp_adjust, addr_valid}, 32'h4, "unstack chain");
    wr(32'h0800);
    chk(32'(unstacking_bus_fault_flag), 32'h0, "unstack clear");
    $display("test unstack done");
  endtask : t_unstack
  task automatic t_imprecise;
    logic [31:0] q;
    exec_prio = 8'h03;
    bus_fault_prio = 8'h05;
    u_core.fire(4'h2, 32'h0);
    chk(32'(imprecise_bus_error_flag), 32'h1, "imprecise flag");
    chk(32'(addr_valid), 32'h0, "imprecise loaded address");
    u_core.fire(4'h1, 32'hA5A5_0F0F);
    chk(bus_fault_address_register, 32'hA5A5_0F0F, "precise address");
    rd(q);
    chk(q, 32'h0600, "imprecise and precise together");
    chk(32'(act_n), 32'h0, "activated while blocked");
    exec_prio = 8'h09;
    repeat (4) @(negedge clock);
    chk(32'(act_n), 32'h1, "pending fault not activated once");
    wr(32'h1C00);
    rd(q);
    chk(q, 32'h0200, "clear of ones only");
    $display("test imprecise done");
  endtask : t_imprecise
  task automatic t_freeze;
    clk_en = 1'b0;
    u_core.fire(4'h8, 32'h0);
    chk({30'h0, sp_adjust, stacking_bus_fault_flag}, 32'h0, "moved while frozen");
    clk_en = 1'b1;
    // Set and write-one clear in the same cycle: set must win
    fork
      u_core.fire(4'h8, 32'h0);
      wr(32'h1000);
    join
    chk(32'(stacking_bus_fault_flag), 32'h1, "clear beat set");
    wr(32'h1000);
    chk(32'(stacking_bus_fault_flag), 32'h0, "stack clear after tie");
    $display("test freeze and tie done");
  endtask : t_freeze
  task automatic t_prio;
    int base;
    base = act_n;
    u_core.fire(4'h2, 32'h0);
    chk(32'(act_n - base), 32'h1, "unblocked fault not active at once");
    exec_prio = 8'h05;
    u_core.fire(4'h2, 32'h0);
    chk(32'(act_n - base), 32'h1, "equal priority did not pend");
    exec_prio = 8'h06;
    repeat (2) @(negedge clock);
    chk(32'(act_n - base), 32'h2, "equal priority fault lost");
    wr(32'h0600);
    chk({30'h0, imprecise_bus_error_flag, precise_flag}, 32'h0, "imprecise clear");
    $display("test priority done");
  endtask : t_prio
  task automatic t_reset;
    u_core.fire(4'h8, 32'h0);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk({30'h0, stacking_bus_fault_flag, addr_valid}, 32'h0, "mid reset flags");
    chk(32'(imprecise_bus_error_flag), 32'h0, "mid reset imprecise");
    chk(bus_fault_address_register, 32'h0, "mid reset address");
    u_core.fire(4'h4, 32'h0);
    chk(32'(unstacking_bus_fault_flag), 32'h1, "first fault after reset");
    wr(32'h0800);
    chk(32'(unstacking_bus_fault_flag), 32'h0, "unstack clear after reset");
    $display("test reset done");
  endtask : t_reset
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    #5000;
    failures++;
    results();
  end
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    chk({29'h0, stacking_bus_fault_flag, unstacking_bus_fault_flag,
         imprecise_bus_error_flag}, 32'h0, "flags after reset");
    t_stack();
    t_freeze();
    t_unstack();
    t_imprecise();
    t_prio();
    t_reset();
    results();
  end
endmodule : bus_fault_status_bits_tb
